/* verilog/afef_defines.svh */
// register indexes, field positions, reset values and filter constants of the converter front end
`ifndef AFEF_DEFINES_SVH
`define AFEF_DEFINES_SVH
`define AFEF_IDX_W 10
`define AFEF_IDX_PWR_A 10'h001
`define AFEF_IDX_PWR_B 10'h002
`define AFEF_IDX_CONV 10'h00E
`define AFEF_IDX_RATE 10'h007
`define AFEF_IDX_ROUTE 10'h02C
`define AFEF_IDX_AMP 10'h02D
`define AFEF_IDX_BOOST 10'h02F
`define AFEF_IDX_STATUS 10'h030
`define AFEF_RST_PWR_A 9'h000
`define AFEF_RST_PWR_B 9'h000
`define AFEF_RST_CONV 9'h100
`define AFEF_RST_RATE 9'h000
`define AFEF_RST_ROUTE 9'h003
`define AFEF_RST_AMP 9'h010
`define AFEF_RST_BOOST 9'h100
`define AFEF_BIT_BIAS_ON 4
`define AFEF_BIT_AUX_EN 6
`define AFEF_BIT_CONV_ON 0
`define AFEF_BIT_AMP_EN 2
`define AFEF_BIT_BOOST_ON 4
`define AFEF_BIT_INVERT 0
`define AFEF_BIT_OSR 3
`define AFEF_CORNER_LSB 4
`define AFEF_BIT_HP_MODE 7
`define AFEF_BIT_HP_ON 8
`define AFEF_BIT_POS_MIC_AMP 0
`define AFEF_BIT_NEG_MIC_AMP 1
`define AFEF_BIT_AUX_AMP 2
`define AFEF_BIT_AUX_MODE 3
`define AFEF_BIT_BIAS_LVL 8
`define AFEF_AMP_VOL_LSB 0
`define AFEF_BIT_ISOLATE 6
`define AFEF_AUX_GAIN_LSB 0
`define AFEF_POS_MIC_GAIN_LSB 4
`define AFEF_BIT_LIFT 8
`define AFEF_RATE_LSB 0
`define AFEF_PATH_OFF 3'h0
`define AFEF_GAIN_MIN_DB 6'h34
`define AFEF_GAIN_STEP_DB 6'h03
`define AFEF_OSR_LO 8'h40
`define AFEF_OSR_HI 8'h80
`define AFEF_SCALE_LO 5'h0E
`define AFEF_SCALE_HI 5'h0D
`define AFEF_HP_AUDIO_SHIFT 4'hB
`define AFEF_HP_CUT_SHIFTS 24'h492492
`define AFEF_HP_CUT_TAB 24'h4926DB
`define AFEF_SMP_MAX 24'h7FFFFF
`define AFEF_SMP_MIN 24'h800000
`define AFEF_FIFO_DEPTH 32
`define AFEF_STATUS_LVL_LSB 3
`endif

/* verilog/afef_pkg.sv */
// types shared by the converter front end
package afef_pkg;
    typedef enum logic [1:0] {AFEF_APB_IDLE, AFEF_APB_SETUP, AFEF_APB_ACCESS} afef_apb_state_t;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } afef_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } afef_apb_rsp_t;
    typedef struct packed {
        logic boost_power;
        logic amp_power;
        logic aux_power;
        logic amp_to_boost_on;
        logic amp_gain_lift_sel;
        logic [5:0] amp_gain_code;
        logic aux_path_on;
        logic signed [5:0] aux_path_gain_db;
        logic pos_mic_path_on;
        logic signed [5:0] pos_mic_path_gain_db;
        logic pos_mic_to_amp;
        logic neg_mic_to_amp;
        logic aux_to_amp;
        logic aux_mixer_mode;
        logic bias_level_sel;
        logic oversample_sel;
        logic converter_on;
    } afef_analog_cfg_t;
endpackage

/* verilog/afef_filter.sv */
// front end control registers, decimation and high-pass path, sample fifo
//
// Behaviour
// - lift bit sets amplifier path into boost mixer at +20dB or 0dB.
// - isolate bit mutes amplifier and disconnects it from boost mixer.
// - aux gain code 000 disconnects; 001..111 give -12dB..+6dB, 3dB steps.
// - positive mic gain code 000 disconnects; 001..111 give -12dB..+6dB.
// - boost mixer powered only while boost enable bit is 1; resets 0.
// - bias output driven only while bias enable is 1, else high impedance.
// - bias level bit selects high level at 0, 0.65 supply at 1.
// - converter and filter path run only while converter enable is 1.
// - invert bit negates output samples; 0 passes them unchanged.
// - oversample bit selects 64x at 0, 128x at 1.
// - path works at 24-bit precision, decimating to the sample rate.
// - high-pass enable bit, reset 1, inserts filter; cleared bypasses it.
// - mode 0 gives first-order high-pass near 3.7Hz.
// - mode 1 gives second-order high-pass, corner from 3-bit field.
// - corner codes scale with rate group so corners track each column.
`timescale 1ns/1ps
`include "afef_defines.svh"

module afef_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `AFEF_FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } afef_fifo_state_t;
    afef_fifo_state_t st_reg;
    afef_fifo_state_t st_next;
    logic full;
    logic empty;

    assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
    assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) && (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = st_reg.mem[st_reg.rd_ptr[AW-1:0]];
    assign level_out = st_reg.wr_ptr - st_reg.rd_ptr;

    always_comb begin
        st_next = st_reg;
        if (wr_valid_in && !full) begin
            st_next.mem[st_reg.wr_ptr[AW-1:0]] = wr_data_in;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (rd_ready_in && !empty) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

module afef_filter (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire afef_pkg::afef_apb_req_t apb_req_in,
    output afef_pkg::afef_apb_rsp_t apb_rsp_out,
    input wire logic signed [3:0] mod_data_in,
    input wire logic mod_valid_in,
    output logic mod_ready_out,
    output logic [23:0] smp_data_out,
    output logic smp_valid_out,
    input wire logic smp_ready_in,
    output afef_pkg::afef_analog_cfg_t analog_cfg_out,
    output logic mic_bias_out_out,
    output logic mic_bias_oe_out
);
    import afef_pkg::*;

    // ******************************
    // state
    // ******************************
    typedef struct packed {
        logic [8:0] pwr_a;
        logic [8:0] pwr_b;
        logic [8:0] conv;
        logic [8:0] rate;
        logic [8:0] route;
        logic [8:0] amp;
        logic [8:0] boost;
        logic [31:0] prdata;
        logic [7:0] cnt;
        logic signed [11:0] acc;
        logic signed [31:0] x1;
        logic signed [31:0] y1;
        logic signed [31:0] x2;
        logic signed [31:0] y2;
        afef_analog_cfg_t cfg;
        logic bias_oe;
    } afef_state_t;
    afef_state_t st_reg;
    afef_state_t st_next;

    logic [`AFEF_IDX_W-1:0] idx;
    logic mapped;
    logic [8:0] rd_mux;
    logic fifo_wr_ready;
    logic [5:0] fifo_level;
    logic push;
    logic [23:0] push_data;

    // ******************************
    // helpers
    // ******************************
    function automatic logic signed [5:0] path_gain_db(input logic [2:0] code);
        logic [5:0] steps;
        steps = 6'({3'h0, code} - 6'h01);
        return 6'(`AFEF_GAIN_MIN_DB + 6'(steps * `AFEF_GAIN_STEP_DB));
    endfunction

    function automatic logic signed [31:0] hp_step(input logic signed [31:0] x, input logic signed [31:0] xp,
                                                   input logic signed [31:0] yp, input logic [3:0] k);
        return yp - (yp >>> k) + x - xp;
    endfunction

    function automatic logic [23:0] sat24(input logic signed [31:0] v);
        if (v > $signed({8'h00, `AFEF_SMP_MAX})) begin
            return `AFEF_SMP_MAX;
        end else if (v < $signed({8'hFF, `AFEF_SMP_MIN})) begin
            return `AFEF_SMP_MIN;
        end
        return v[23:0];
    endfunction

    // ******************************
    // apb decode
    // ******************************
    assign idx = apb_req_in.paddr[11:2];

    always_comb begin
        mapped = apb_req_in.paddr[1:0] == 2'h0;
        rd_mux = 9'h000;
        case (idx)
            `AFEF_IDX_PWR_A: begin
                rd_mux = st_reg.pwr_a;
            end
            `AFEF_IDX_PWR_B: begin
                rd_mux = st_reg.pwr_b;
            end
            `AFEF_IDX_CONV: begin
                rd_mux = st_reg.conv;
            end
            `AFEF_IDX_RATE: begin
                rd_mux = st_reg.rate;
            end
            `AFEF_IDX_ROUTE: begin
                rd_mux = st_reg.route;
            end
            `AFEF_IDX_AMP: begin
                rd_mux = st_reg.amp;
            end
            `AFEF_IDX_BOOST: begin
                rd_mux = st_reg.boost;
            end
            `AFEF_IDX_STATUS: begin
                rd_mux = {fifo_level, !fifo_wr_ready, smp_valid_out, st_reg.pwr_b[`AFEF_BIT_CONV_ON]};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // zero wait state: read data is caught in the setup cycle
    assign apb_rsp_out.prdata = st_reg.prdata;
    assign apb_rsp_out.pready = 1'b1;
    assign apb_rsp_out.pslverr = apb_req_in.psel && apb_req_in.penable && !mapped;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        logic wr;
        logic conv_on;
        logic [3:0] k2;
        logic [1:0] adj;
        logic [2:0] corner;
        logic signed [31:0] dec;
        logic signed [31:0] h1;
        logic signed [31:0] h2;
        logic signed [31:0] filt;
        logic [23:0] s24;
        logic [7:0] last;
        logic [4:0] scale;
        wr = 1'b0;
        conv_on = 1'b0;
        k2 = 4'h0;
        adj = 2'h0;
        corner = 3'h0;
        dec = '0;
        h1 = '0;
        h2 = '0;
        filt = '0;
        s24 = '0;
        last = 8'h00;
        scale = 5'h00;
        st_next = st_reg;
        push = 1'b0;
        push_data = 24'h000000;

        if (apb_req_in.psel && !apb_req_in.penable) begin
            st_next.prdata = {23'h000000, rd_mux};
        end
        wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && mapped;
        if (wr) begin
            case (idx)
                `AFEF_IDX_PWR_A: begin
                    st_next.pwr_a = apb_req_in.pwdata[8:0];
                end
                `AFEF_IDX_PWR_B: begin
                    st_next.pwr_b = apb_req_in.pwdata[8:0];
                end
                `AFEF_IDX_CONV: begin
                    st_next.conv = apb_req_in.pwdata[8:0];
                end
                `AFEF_IDX_RATE: begin
                    st_next.rate = {6'h00, apb_req_in.pwdata[2:0]};
                end
                `AFEF_IDX_ROUTE: begin
                    st_next.route = apb_req_in.pwdata[8:0];
                end
                `AFEF_IDX_AMP: begin
                    st_next.amp = apb_req_in.pwdata[8:0];
                end
                `AFEF_IDX_BOOST: begin
                    st_next.boost = apb_req_in.pwdata[8:0];
                end
                default: begin
                end
            endcase
        end

        // analog configuration decode
        st_next.cfg.boost_power = st_reg.pwr_b[`AFEF_BIT_BOOST_ON];
        st_next.cfg.amp_power = st_reg.pwr_b[`AFEF_BIT_AMP_EN];
        st_next.cfg.aux_power = st_reg.pwr_a[`AFEF_BIT_AUX_EN];
        st_next.cfg.amp_to_boost_on = !st_reg.amp[`AFEF_BIT_ISOLATE];
        st_next.cfg.amp_gain_lift_sel = st_reg.boost[`AFEF_BIT_LIFT] && !st_reg.amp[`AFEF_BIT_ISOLATE];
        st_next.cfg.amp_gain_code = st_reg.amp[`AFEF_AMP_VOL_LSB +: 6];
        st_next.cfg.aux_path_on = st_reg.boost[`AFEF_AUX_GAIN_LSB +: 3] != `AFEF_PATH_OFF;
        st_next.cfg.aux_path_gain_db = st_next.cfg.aux_path_on ?
            path_gain_db(st_reg.boost[`AFEF_AUX_GAIN_LSB +: 3]) : 6'sh00;
        st_next.cfg.pos_mic_path_on = st_reg.boost[`AFEF_POS_MIC_GAIN_LSB +: 3] != `AFEF_PATH_OFF;
        st_next.cfg.pos_mic_path_gain_db = st_next.cfg.pos_mic_path_on ?
            path_gain_db(st_reg.boost[`AFEF_POS_MIC_GAIN_LSB +: 3]) : 6'sh00;
        st_next.cfg.pos_mic_to_amp = st_reg.route[`AFEF_BIT_POS_MIC_AMP];
        st_next.cfg.neg_mic_to_amp = st_reg.route[`AFEF_BIT_NEG_MIC_AMP];
        st_next.cfg.aux_to_amp = st_reg.route[`AFEF_BIT_AUX_AMP];
        st_next.cfg.aux_mixer_mode = st_reg.route[`AFEF_BIT_AUX_MODE];
        st_next.cfg.bias_level_sel = st_reg.route[`AFEF_BIT_BIAS_LVL];
        st_next.cfg.oversample_sel = st_reg.conv[`AFEF_BIT_OSR];
        st_next.cfg.converter_on = st_reg.pwr_b[`AFEF_BIT_CONV_ON];
        st_next.bias_oe = st_reg.pwr_a[`AFEF_BIT_BIAS_ON];

        // decimation: boxcar sum over one oversampling frame
        conv_on = st_reg.pwr_b[`AFEF_BIT_CONV_ON];
        last = st_reg.conv[`AFEF_BIT_OSR] ? `AFEF_OSR_HI - 8'h01 : `AFEF_OSR_LO - 8'h01;
        scale = st_reg.conv[`AFEF_BIT_OSR] ? `AFEF_SCALE_HI : `AFEF_SCALE_LO;
        case (st_reg.rate[`AFEF_RATE_LSB +: 3])
            3'h5, 3'h4: begin
                adj = 2'h0;
            end
            3'h3, 3'h2: begin
                adj = 2'h1;
            end
            default: begin
                adj = 2'h2;
            end
        endcase
        corner = st_reg.conv[`AFEF_CORNER_LSB +: 3];
        k2 = 4'({1'b0, 3'(`AFEF_HP_CUT_TAB >> (3 * corner))}) + 4'({2'h0, adj});

        if (!conv_on) begin
            // converter off: path held cleared
            st_next.cnt = 8'h00;
            st_next.acc = '0;
            st_next.x1 = '0;
            st_next.y1 = '0;
            st_next.x2 = '0;
            st_next.y2 = '0;
        end else if (mod_valid_in && mod_ready_out) begin
            st_next.acc = st_reg.acc + 12'(mod_data_in);
            st_next.cnt = st_reg.cnt + 8'h01;
            if (st_reg.cnt >= last) begin
                dec = 32'(st_next.acc) <<< scale;
                st_next.acc = '0;
                st_next.cnt = 8'h00;
                if (st_reg.conv[`AFEF_BIT_HP_MODE]) begin
                    h1 = hp_step(dec, st_reg.x1, st_reg.y1, k2);
                    h2 = hp_step(h1, st_reg.x2, st_reg.y2, k2);
                end else begin
                    h1 = hp_step(dec, st_reg.x1, st_reg.y1, `AFEF_HP_AUDIO_SHIFT);
                    h2 = h1;
                end
                st_next.x1 = dec;
                st_next.y1 = h1;
                st_next.x2 = h1;
                st_next.y2 = h2;
                filt = st_reg.conv[`AFEF_BIT_HP_ON] ? h2 : dec;
                s24 = sat24(filt);
                if (st_reg.conv[`AFEF_BIT_INVERT]) begin
                    push_data = (s24 == `AFEF_SMP_MIN) ? `AFEF_SMP_MAX : 24'(-s24);
                end else begin
                    push_data = s24;
                end
                push = 1'b1;
            end
        end
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
            st_reg.pwr_a <= `AFEF_RST_PWR_A;
            st_reg.pwr_b <= `AFEF_RST_PWR_B;
            st_reg.conv <= `AFEF_RST_CONV;
            st_reg.rate <= `AFEF_RST_RATE;
            st_reg.route <= `AFEF_RST_ROUTE;
            st_reg.amp <= `AFEF_RST_AMP;
            st_reg.boost <= `AFEF_RST_BOOST;
            st_reg.cfg.amp_to_boost_on <= 1'b1;
            st_reg.cfg.amp_gain_lift_sel <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ******************************
    // outputs and sample fifo
    // ******************************
    // a frame end pushes the same cycle, so accepting only while fifo has room never loses a sample
    assign mod_ready_out = st_reg.pwr_b[`AFEF_BIT_CONV_ON] && fifo_wr_ready;
    assign analog_cfg_out = st_reg.cfg;
    assign mic_bias_out_out = st_reg.bias_oe;
    assign mic_bias_oe_out = st_reg.bias_oe;

    afef_fifo #(
        .WIDTH(24),
        .DEPTH(`AFEF_FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .wr_data_in(push_data),
        .wr_valid_in(push),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(smp_data_out),
        .rd_valid_out(smp_valid_out),
        .rd_ready_in(smp_ready_in),
        .level_out(fifo_level)
    );
endmodule

/* dv/afef_chk.sv */
// concurrent checks on the converter front end ports
`timescale 1ns/1ps
`include "afef_defines.svh"
module afef_chk (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire afef_pkg::afef_apb_req_t apb_req_in,
    input wire afef_pkg::afef_apb_rsp_t apb_rsp_out,
    input wire logic signed [3:0] mod_data_in,
    input wire logic mod_valid_in,
    input wire logic mod_ready_out,
    input wire logic [23:0] smp_data_out,
    input wire logic smp_valid_out,
    input wire logic smp_ready_in,
    input wire afef_pkg::afef_analog_cfg_t analog_cfg_out,
    input wire logic mic_bias_out_out,
    input wire logic mic_bias_oe_out
);
    import afef_pkg::*;
    // ****************************************
    // write capture and gain decode
    // ****************************************
    logic [31:0] wd_q;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wd_q <= 32'h0;
        end else if (apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite) begin
            wd_q <= apb_req_in.pwdata;
        end
    end
    function automatic logic signed [5:0] db_of(input logic [2:0] c);
        return (c == 3'h0) ? 6'h00 : 6'(3 * c) - 6'h0F;
    endfunction
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_wr(logic [9:0] i);
        apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && apb_req_in.paddr == {i, 2'h0};
    endsequence
    // register loads at the write edge, the config flop one edge later
    a_bias_oe_tie: assert property (mic_bias_oe_out == mic_bias_out_out) else $error("bias oe mismatch");
    a_bias_write: assert property (s_wr(`AFEF_IDX_PWR_A) |-> ##2 mic_bias_oe_out == wd_q[4])
        else $error("bias enable not taken");
    a_boost_write: assert property (s_wr(`AFEF_IDX_PWR_B) |-> ##2
        analog_cfg_out.boost_power == wd_q[4] && analog_cfg_out.converter_on == wd_q[0])
        else $error("power b not taken");
    a_osr_write: assert property (s_wr(`AFEF_IDX_CONV) |-> ##2 analog_cfg_out.oversample_sel == wd_q[3])
        else $error("oversample select not taken");
    a_ready_off: assert property (mod_ready_out |=> analog_cfg_out.converter_on)
        else $error("ready while converter off");
    a_isolate_lift: assert property (s_wr(`AFEF_IDX_AMP) ##0 apb_req_in.pwdata[6] |-> ##2
        !analog_cfg_out.amp_to_boost_on && !analog_cfg_out.amp_gain_lift_sel) else $error("isolate ignored");
    a_aux_decode: assert property (s_wr(`AFEF_IDX_BOOST) |-> ##2
        analog_cfg_out.aux_path_on == (wd_q[2:0] != 3'h0) && analog_cfg_out.aux_path_gain_db == db_of(wd_q[2:0])
        && analog_cfg_out.amp_gain_lift_sel == (wd_q[8] && analog_cfg_out.amp_to_boost_on))
        else $error("aux gain decode wrong");
    a_pos_decode: assert property (s_wr(`AFEF_IDX_BOOST) |-> ##2
        analog_cfg_out.pos_mic_path_on == (wd_q[6:4] != 3'h0)
        && analog_cfg_out.pos_mic_path_gain_db == db_of(wd_q[6:4])) else $error("mic gain decode wrong");
    a_smp_hold: assert property (smp_valid_out && !smp_ready_in |=> smp_valid_out && $stable(smp_data_out))
        else $error("sample dropped while stalled");
endmodule

/* dv/afef_sink.sv */
// audio interface model taking filtered samples, can stall
`timescale 1ns/1ps
module afef_sink (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [23:0] smp_data_in,
    input wire logic smp_valid_in,
    output logic smp_ready_out,
    input wire logic stall_in
);
    logic [23:0] got[$];
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            smp_ready_out <= 1'b0;
        end else begin
            if (smp_valid_in === 1'b1 && smp_ready_out) begin
                got.push_back(smp_data_in);
            end
            smp_ready_out <= !stall_in;
        end
    end
endmodule

/* dv/tb.sv */
// self-checking bench for the converter front end
`timescale 1ns/1ps
`include "afef_defines.svh"
module tb;
    import afef_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    afef_apb_req_t req = '0;
    afef_apb_rsp_t rsp;
    logic [3:0] mod_data = 4'h0;
    logic mod_valid = 1'b0;
    logic mod_ready;
    logic [23:0] smp_data;
    logic smp_valid;
    logic smp_ready;
    logic stall = 1'b0;
    afef_analog_cfg_t cfg;
    logic bias;
    logic bias_oe;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int b;
    logic [31:0] rd;
    logic err;
    logic [5:0] e;
    logic [9:0] idx_t[7] = '{`AFEF_IDX_PWR_A, `AFEF_IDX_PWR_B, `AFEF_IDX_CONV, `AFEF_IDX_RATE,
        `AFEF_IDX_ROUTE, `AFEF_IDX_AMP, `AFEF_IDX_BOOST};
    logic [8:0] rst_t[7] = '{9'h000, 9'h000, 9'h100, 9'h000, 9'h003, 9'h010, 9'h100};
    always #50 mclk_in = ~mclk_in;
    afef_filter dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req), .apb_rsp_out(rsp),
        .mod_data_in(mod_data), .mod_valid_in(mod_valid), .mod_ready_out(mod_ready), .smp_data_out(smp_data),
        .smp_valid_out(smp_valid), .smp_ready_in(smp_ready), .analog_cfg_out(cfg), .mic_bias_out_out(bias),
        .mic_bias_oe_out(bias_oe));
    afef_sink sink_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .smp_data_in(smp_data),
        .smp_valid_in(smp_valid), .smp_ready_out(smp_ready), .stall_in(stall));
    // ****************************************
    // tasks
    // ****************************************
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'h0};
    endfunction
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_in);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge mclk_in);
        req.penable <= 1'b1;
        @(posedge mclk_in);
        while (rsp.pready !== 1'b1) @(posedge mclk_in);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic settle();
        @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic feed(input logic [3:0] v, input int n);
        int k;
        logic r;
        k = 0;
        @(posedge mclk_in);
        mod_data <= v;
        mod_valid <= 1'b1;
        while (k < n) begin
            @(negedge mclk_in);
            r = mod_ready;
            @(posedge mclk_in);
            if (r === 1'b1) k++;
        end
        mod_valid <= 1'b0;
    endtask
    task automatic wait_got(input int n);
        while (sink_u.got.size() < n) @(posedge mclk_in);
    endtask
    task automatic run(input logic [8:0] conv, input logic [2:0] rate, input logic [3:0] v, input int nfr,
                       input logic [23:0] e0, input logic [23:0] e1);
        int s;
        s = sink_u.got.size();
        apb(ba(`AFEF_IDX_PWR_B), 1'b1, 32'h0);
        apb(ba(`AFEF_IDX_RATE), 1'b1, {29'h0, rate});
        apb(ba(`AFEF_IDX_CONV), 1'b1, {23'h0, conv});
        apb(ba(`AFEF_IDX_PWR_B), 1'b1, 32'h11);
        feed(v, nfr * (conv[3] ? 128 : 64));
        wait_got(s + nfr);
        chk({8'h0, sink_u.got[s]}, {8'h0, e0});
        if (nfr > 1) chk({8'h0, sink_u.got[s + 1]}, {8'h0, e1});
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(ba(idx_t[i]), 1'b0, 32'h0);
            chk(rd, {23'h0, rst_t[i]});
        end
        apb(12'h005, 1'b1, 32'h1FF);
        chk({31'h0, err}, 32'h1);
        apb(12'h100, 1'b0, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(ba(`AFEF_IDX_PWR_A), 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        apb(ba(`AFEF_IDX_PWR_A), 1'b1, 32'h10);
        apb(ba(`AFEF_IDX_ROUTE), 1'b1, 32'h102);
        apb(ba(`AFEF_IDX_AMP), 1'b1, 32'h50);
        settle();
        chk({bias, bias_oe, cfg.bias_level_sel, cfg.amp_to_boost_on, cfg.amp_gain_lift_sel}, 32'h1C);
        chk({31'h0, mod_ready}, 32'h0);
        apb(ba(`AFEF_IDX_PWR_A), 1'b1, 32'h0);
        apb(ba(`AFEF_IDX_AMP), 1'b1, 32'h10);
        apb(ba(`AFEF_IDX_PWR_B), 1'b1, 32'h10);
        apb(ba(`AFEF_IDX_CONV), 1'b1, 32'h108);
        settle();
        chk({bias, bias_oe, cfg.amp_gain_lift_sel, cfg.boost_power, cfg.converter_on, cfg.oversample_sel},
            32'h0D);
        for (int c = 0; c < 8; c++) begin
            e = (c == 0) ? 6'h00 : 6'(3 * c - 15);
            apb(ba(`AFEF_IDX_BOOST), 1'b1, 32'(c[0] * 256 + c * 17));
            settle();
            chk({cfg.aux_path_on, cfg.aux_path_gain_db, cfg.pos_mic_path_on, cfg.pos_mic_path_gain_db,
                cfg.amp_gain_lift_sel}, {(c != 0), e, (c != 0), e, c[0]});
        end
        $display("test analog config done");
        run(9'h000, 3'h0, 4'h1, 1, 24'h100000, 24'h0);
        run(9'h009, 3'h0, 4'h1, 1, 24'hF00000, 24'h0);
        run(9'h001, 3'h0, 4'h8, 1, 24'h7FFFFF, 24'h0);
        run(9'h008, 3'h0, 4'h8, 1, 24'h800000, 24'h0);
        run(9'h100, 3'h0, 4'h1, 2, 24'h100000, 24'h0FFE00);
        run(9'h180, 3'h0, 4'h1, 2, 24'h100000, 24'h0F0000);
        run(9'h180, 3'h5, 4'h1, 2, 24'h100000, 24'h0C0000);
        run(9'h180, 3'h3, 4'h1, 2, 24'h100000, 24'h0E0000);
        run(9'h1F0, 3'h3, 4'h1, 2, 24'h100000, 24'h0C0000);
        $display("test filter path done");
        stall <= 1'b1;
        b = sink_u.got.size();
        apb(ba(`AFEF_IDX_CONV), 1'b1, 32'h0);
        feed(4'h1, 32 * 64);
        apb(ba(`AFEF_IDX_STATUS), 1'b0, 32'h0);
        chk(rd, 32'h107);
        @(negedge mclk_in);
        chk({31'h0, mod_ready}, 32'h0);
        @(posedge mclk_in);
        stall <= 1'b0;
        wait_got(b + 32);
        chk({8'h0, sink_u.got[b + 31]}, 32'h100000);
        apb(ba(`AFEF_IDX_STATUS), 1'b0, 32'h0);
        chk(rd, 32'h1);
        $display("test buffer done");
        conclude();
    end
endmodule
bind afef_filter afef_chk chk_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .apb_req_in(apb_req_in),
    .apb_rsp_out(apb_rsp_out), .mod_data_in(mod_data_in), .mod_valid_in(mod_valid_in),
    .mod_ready_out(mod_ready_out), .smp_data_out(smp_data_out), .smp_valid_out(smp_valid_out),
    .smp_ready_in(smp_ready_in), .analog_cfg_out(analog_cfg_out), .mic_bias_out_out(mic_bias_out_out),
    .mic_bias_oe_out(mic_bias_oe_out));
